// [rtl/autosave_host.v]
// Purpose: Host that plays the six-read pattern switching power-loss save
// Assumes: Sole master of the SRAM bus while a sequence runs
// Notes: The low-supply pin passes three flops, the request pins none; a low-supply level aborts requests
`timescale 1ns/1ps
`include "autosave_host_defines.vh"

// Function
// RULE1 - Reads 0x0E38, 0x31C7, 0x03E0 first, in order
// RULE2 - Fourth 0x3C1F, fifth 0x303F
// RULE3 - Sixth read 0x0B45 turns save off
// RULE4 - Sixth read 0x0B46 turns save on
// RULE5 - Every access is chip-select timed read
// RULE6 - Manual save follows change to persist it; code saves only after the boot rewrite, not req_disable/req_enable
// RULE7 - Device ships with save enabled
// RULE8 - Device ignores saves and writes at low supply
// RULE9 - Write held at power-up is blocked
// RULE10 - Shipped cells read zero; no assumption
// RULE11 - Boot rewrites desired save setting
// RULE12 - Only low 14 address bits matter
// RULE13 - Write strobe stays high all six reads
// RULE14 - No other access between pattern reads
// RULE15 - Sequence restarts from first address
module autosave_host #(
    parameter ADDR_WIDTH = 15,
    parameter BOOT_ENABLE = 1
) (
    input wire clk,
    input wire rst_n,
    input wire req_disable,
    input wire req_enable,
    input wire req_save,
    input wire low_supply,
    output reg [ADDR_WIDTH-1:0] sram_addr,
    output reg sram_ce_n,
    output reg sram_oe_n,
    output reg sram_we_n,
    output reg busy,
    output reg done,
    output reg aborted,
    output reg save_setting
);
    localparam S_IDLE = 4'b0001;
    localparam S_READ = 4'b0010;
    localparam S_GAP = 4'b0100;
    localparam S_END = 4'b1000;
    localparam [2:0] OP_OFF = 3'h0;
    localparam [2:0] OP_ON = 3'h1;
    localparam [2:0] OP_SAVE = 3'h2;

    reg [3:0] state;
    reg [2:0] step;
    reg [2:0] op;
    reg boot_pending;
    reg low_s1, low_s2, low_s3;
    reg low_level;
    wire tmr_done;
    wire tmr_busy;
    reg tmr_load;
    reg [3:0] tmr_len;

    // Step address; sixth read picks off, on or save
    function [13:0] pat_addr;
        input [2:0] idx;
        input [2:0] kind;
        begin
            case (idx)
                3'h0: pat_addr = `PAT_ADDR_1; // [RULE1]
                3'h1: pat_addr = `PAT_ADDR_2; // [RULE1]
                3'h2: pat_addr = `PAT_ADDR_3; // [RULE1]
                3'h3: pat_addr = `PAT_ADDR_4; // [RULE2]
                3'h4: pat_addr = `PAT_ADDR_5; // [RULE2]
                default: begin
                    if (kind == OP_OFF) begin
                        pat_addr = `PAT_ADDR_OFF; // [RULE3]
                    end else if (kind == OP_ON) begin
                        pat_addr = `PAT_ADDR_ON; // [RULE4]
                    end else begin
                        pat_addr = `SAVE_ADDR; // [RULE6]
                    end
                end
            endcase
        end
    endfunction

    // Cuts a cycle count down to the timer width
    function [3:0] cycle_len;
        input integer cycles;
        begin
            cycle_len = cycles[3:0];
        end
    endfunction

    // Low-supply pin synchroniser, change counted when s2 and s3 agree
    always @(posedge clk) begin
        if (!rst_n) begin
            low_s1 <= 1'b0;
            low_s2 <= 1'b0;
            low_s3 <= 1'b0;
            low_level <= 1'b0;
        end else begin
            low_s1 <= low_supply;
            low_s2 <= low_s1;
            low_s3 <= low_s2;
            if (low_s2 == low_s3) begin
                low_level <= low_s2;
            end
        end
    end

    strobe_timer #(
        .WIDTH(4)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .length(tmr_len),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    always @(posedge clk) begin
        tmr_load <= 1'b0;
        if (!rst_n) begin
            state <= S_IDLE;
            step <= 3'h0;
            op <= OP_ON;
            boot_pending <= 1'b1;
            sram_addr <= {ADDR_WIDTH{1'b0}};
            sram_ce_n <= 1'b1;
            sram_oe_n <= 1'b1;
            sram_we_n <= 1'b1;
            busy <= 1'b0;
            done <= 1'b0;
            aborted <= 1'b0;
            save_setting <= 1'b1; // [RULE7]
            tmr_len <= 4'h0;
        end else begin
            done <= 1'b0;
            aborted <= 1'b0;
            case (state)
                S_IDLE: begin
                    sram_we_n <= 1'b1; // [RULE13]
                    if (!low_level && (boot_pending || req_disable || req_enable || req_save)) begin
                        // Boot pass rewrites the setting, then a save follows [RULE11]
                        if (boot_pending && op == OP_SAVE) begin
                            op <= OP_SAVE; // [RULE6]
                        end else if (boot_pending) begin
                            op <= (BOOT_ENABLE != 0) ? OP_ON : OP_OFF;
                        end else if (req_disable) begin
                            op <= OP_OFF;
                        end else if (req_enable) begin
                            op <= OP_ON;
                        end else begin
                            op <= OP_SAVE;
                        end
                        step <= 3'h0;
                        busy <= 1'b1;
                        state <= S_GAP;
                        tmr_len <= cycle_len(`GAP_CYCLES);
                        tmr_load <= 1'b1;
                    end else if (low_level && (req_disable || req_enable || req_save)) begin
                        aborted <= 1'b1; // [RULE8]
                    end
                end
                S_GAP: begin
                    if (tmr_done) begin
                        // Chip-select timed read, upper address line held low [RULE5] [RULE12]
                        sram_addr <= {{(ADDR_WIDTH-14){1'b0}}, pat_addr(step, op)};
                        sram_ce_n <= 1'b0;
                        sram_oe_n <= 1'b0;
                        sram_we_n <= 1'b1; // [RULE13]
                        tmr_len <= cycle_len(`READ_CYCLES);
                        tmr_load <= 1'b1;
                        state <= S_READ;
                    end
                end
                S_READ: begin
                    if (tmr_done) begin
                        sram_ce_n <= 1'b1;
                        sram_oe_n <= 1'b1;
                        if (low_level) begin
                            // Pattern cut short; device would drop it anyway [RULE14]
                            aborted <= 1'b1;
                            state <= S_END;
                        end else if (step == `PAT_LEN - 3'h1) begin
                            state <= S_END;
                            done <= 1'b1;
                            if (op == OP_OFF) begin
                                save_setting <= 1'b0; // [RULE3]
                            end else if (op == OP_ON) begin
                                save_setting <= 1'b1; // [RULE4]
                            end
                        end else begin
                            // No other access is issued between reads [RULE14]
                            step <= step + 3'h1;
                            tmr_len <= cycle_len(`GAP_CYCLES);
                            tmr_load <= 1'b1;
                            state <= S_GAP;
                        end
                    end
                end
                S_END: begin
                    step <= 3'h0; // [RULE15]
                    busy <= 1'b0;
                    state <= S_IDLE;
                    if (boot_pending && op != OP_SAVE) begin
                        // Persist the rewritten setting with a manual save [RULE6]
                        op <= OP_SAVE;
                        boot_pending <= 1'b1;
                        if (!aborted) begin
                            boot_pending <= 1'b1;
                        end
                    end else begin
                        boot_pending <= 1'b0;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
            if (state == S_IDLE && boot_pending && op == OP_SAVE && !low_level) begin
                boot_pending <= 1'b0;
            end
        end
    end
endmodule // autosave_host

// [shared/autosave_host_defines.vh]
// Purpose: Constants for the host that drives the save-control pattern
// Assumes: 50 MHz clock, asynchronous SRAM bus with active-low strobes
// Notes: Pattern addresses compare on the low 14 bits only
`ifndef AUTOSAVE_HOST_DEFINES_VH
`define AUTOSAVE_HOST_DEFINES_VH

`define PAT_ADDR_1 14'h0e38
`define PAT_ADDR_2 14'h31c7
`define PAT_ADDR_3 14'h03e0
`define PAT_ADDR_4 14'h3c1f
`define PAT_ADDR_5 14'h303f
`define PAT_ADDR_OFF 14'h0b45
`define PAT_ADDR_ON 14'h0b46
`define PAT_LEN 3'h6
`define SAVE_ADDR 14'h0fc0
`define CLK_PERIOD_NS 20
`define READ_CYCLE_NS 60
`define READ_CYCLES ((`READ_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_NS 20
`define GAP_CYCLES ((`GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/strobe_timer.v]
// Purpose: Counts the cycles of one strobe phase
// Assumes: Loaded with a length, counts down to one
// Notes: done is a one-cycle pulse on the last cycle
`timescale 1ns/1ps

module strobe_timer #(
    parameter WIDTH = 4
) (
    input wire clk,
    input wire rst_n,
    input wire load,
    input wire [WIDTH-1:0] length,
    output reg busy,
    output wire done
);
    reg [WIDTH-1:0] count;

    assign done = busy && (count == {{(WIDTH-1){1'b0}}, 1'b1});

    always @(posedge clk) begin
        if (!rst_n) begin
            count <= {WIDTH{1'b0}};
            busy <= 1'b0;
        end else if (load) begin
            count <= length;
            busy <= 1'b1;
        end else if (busy) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            if (done) begin
                busy <= 1'b0;
            end
        end
    end
endmodule // strobe_timer

// [tb/autosave_host_sva.sv]
// Purpose: Bus checks on the host side of the save-control pattern
// Assumes: Pattern of six chip-select timed reads
// Notes: Bound into every autosave_host instance
`timescale 1ns/1ps
`include "autosave_host_defines.vh"
module autosave_host_sva #(
    parameter ADDR_WIDTH = 15
) (
    input wire clk,
    input wire rst_n,
    input wire req_disable,
    input wire req_enable,
    input wire req_save,
    input wire low_supply,
    input wire [ADDR_WIDTH-1:0] sram_addr,
    input wire sram_ce_n,
    input wire sram_oe_n,
    input wire sram_we_n,
    input wire busy,
    input wire done,
    input wire aborted,
    input wire save_setting
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    we_held_high_a:
        assert property (sram_we_n) else $error("write strobe low");
    strobes_paired_a:
        assert property (sram_ce_n == sram_oe_n) else $error("strobes differ");
    top_bit_low_a:
        assert property (!sram_ce_n |-> !sram_addr[ADDR_WIDTH-1]) else $error("top address bit set");
    addr_stable_a:
        assert property (!sram_ce_n ##1 !sram_ce_n |-> $stable(sram_addr)) else $error("address moved");
    read_length_a:
        assert property ($fell(sram_ce_n) |-> !sram_ce_n [*4] ##1 sram_ce_n) else $error("read length");
    read_gap_a:
        assert property ($rose(sram_ce_n) |-> sram_ce_n [*2]) else $error("gap too short");
    first_addr_a:
        assert property ($rose(busy) |-> ##[1:8] (!sram_ce_n && sram_addr[13:0] == `PAT_ADDR_1))
            else $error("first read wrong");
    sixth_addr_a:
        assert property (done |-> $past(sram_addr[13:0]) inside {`PAT_ADDR_OFF, `PAT_ADDR_ON, `SAVE_ADDR})
            else $error("sixth read wrong");
    idle_quiet_a:
        assert property (!busy && !$past(busy) |-> sram_ce_n) else $error("access while idle");
    abort_quiet_a:
        assert property (aborted |=> sram_ce_n && !done) else $error("access after abort");
endmodule // autosave_host_sva
bind autosave_host autosave_host_sva #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.clk, .rst_n, .req_disable, .req_enable,
    .req_save, .low_supply, .sram_addr, .sram_ce_n, .sram_oe_n, .sram_we_n, .busy, .done, .aborted, .save_setting);

// [tb/nv_device_model.sv]
// Purpose: Device that decodes the six-read pattern
// Assumes: Reads sampled on the clock, start at chip-select fall
// Notes: Counts saves, holds power-loss save setting
`timescale 1ns/1ps
`include "autosave_host_defines.vh"
module nv_device_model (
    input wire clk,
    input wire rst_n,
    input wire [14:0] sram_addr,
    input wire sram_ce_n,
    input wire sram_oe_n,
    input wire sram_we_n,
    input wire low_supply,
    output reg auto_save,
    output reg [2:0] step,
    output reg [3:0] saves
);
    reg ce_q;
    wire rd = ce_q && !sram_ce_n && !sram_oe_n && sram_we_n;
    wire [13:0] a = sram_addr[13:0];
    wire [13:0] want = step == 3'h0 ? `PAT_ADDR_1 : step == 3'h1 ? `PAT_ADDR_2 : step == 3'h2 ? `PAT_ADDR_3 :
        step == 3'h3 ? `PAT_ADDR_4 : `PAT_ADDR_5;
    always @(posedge clk) begin
        ce_q <= sram_ce_n;
        if (!rst_n) begin
            auto_save <= 1'b1;
            step <= 3'h0;
            saves <= 4'h0;
            ce_q <= 1'b1;
        end else if (!sram_we_n && !sram_ce_n) begin
            step <= 3'h0;
        end else if (rd && step < 3'h5) begin
            step <= (a == want) ? step + 3'h1 : 3'h0;
        end else if (rd) begin
            step <= 3'h0;
            if (a == `PAT_ADDR_OFF)
                auto_save <= 1'b0;
            if (a == `PAT_ADDR_ON)
                auto_save <= 1'b1;
            if (a == `SAVE_ADDR && !low_supply)
                saves <= saves + 4'h1;
        end
    end
endmodule // nv_device_model

// [tb/autosave_host_tb.sv]
// Purpose: Self-checking bench for autosave_host
// Assumes: 50 MHz clock, inputs moved 1 ns after the edge
// Notes: Rows give requests and the setting they should leave
`timescale 1ns/1ps
module autosave_host_tb;
    reg clk = 0, rst_n = 0, req_disable = 0, req_enable = 0, req_save = 0, low_supply = 0, saw_abort = 0;
    wire [14:0] sram_addr;
    wire sram_ce_n, sram_oe_n, sram_we_n, busy, done, aborted, save_setting, auto_save;
    wire [2:0] step;
    wire [3:0] saves;
    reg [3:0] exp_saves;
    int errors = 0, num_checks = 0, k;
    // Disable, enable, save, expected setting
    logic [3:0] rows [0:4] = '{4'b1000, 4'b0010, 4'b0101, 4'b1100, 4'b0010};
    always #10 clk = ~clk;
    always @(posedge clk) if (aborted === 1'b1) saw_abort <= 1'b1;
    autosave_host dut (.clk, .rst_n, .req_disable, .req_enable, .req_save, .low_supply, .sram_addr,
        .sram_ce_n, .sram_oe_n, .sram_we_n, .busy, .done, .aborted, .save_setting);
    nv_device_model dev (.clk, .rst_n, .sram_addr, .sram_ce_n, .sram_oe_n, .sram_we_n, .low_supply,
        .auto_save, .step, .saves);
    task check(input string name, input logic [3:0] exp, input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, got);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) begin @(posedge clk); #1; end
    endtask
    task wait_idle(input logic [3:0] n);
        int i;
        for (i = 0; i < 600 && (busy !== 1'b0 || saves !== n); i++) tick(1);
        if (i == 600) begin errors++; tally_and_finish; end
    endtask
    task run(input logic [2:0] r);
        {req_disable, req_enable, req_save} = r;
        tick(2);
        {req_disable, req_enable, req_save} = 3'h0;
    endtask
    initial begin
        tick(2);
        rst_n = 1;
        check("setting_reset", 4'h1, save_setting);
        wait_idle(4'h1);
        check("boot_auto", 4'h1, auto_save);
        exp_saves = 4'h1;
        for (k = 0; k < 5; k++) begin
            run(rows[k][3:1]);
            exp_saves = exp_saves + rows[k][1];
            wait_idle(exp_saves);
            check("auto_save", rows[k][0], auto_save);
            check("save_setting", rows[k][0], save_setting);
            check("step", 4'h0, step);
        end
        low_supply = 1;
        tick(5);
        run(3'h1);
        tick(3);
        check("aborted", 4'h1, saw_abort);
        check("saves_low", exp_saves, saves);
        low_supply = 0;
        tick(5);
        run(3'h2);
        wait_idle(exp_saves);
        check("setting_after_low", 4'h1, save_setting);
        run(3'h4);
        wait_idle(exp_saves);
        check("auto_after_low", 4'h0, auto_save);
        run(3'h2);
        tick(3);
        check("ce_mid", 4'h0, sram_ce_n);
        rst_n = 0;
        tick(2);
        check("setting_rst", 4'h1, save_setting);
        check("ce_rst", 4'h1, sram_ce_n);
        rst_n = 1;
        wait_idle(4'h1);
        check("auto_rst", 4'h1, auto_save);
        tally_and_finish;
    end
endmodule // autosave_host_tb
